// ---- src/otwtd_pkg.sv ----
package otwtd_pkg;

   // Command codes
   localparam logic [7:0]  CMD_WARN_LIMIT     = 8'h51;
   localparam logic [7:0]  CMD_POWER_ON_WAIT_TIME      = 8'h60;

   // Word layout of both linear words
   localparam int unsigned MANT_WIDTH         = 11;
   localparam int unsigned EXP_WIDTH          = 5;
   localparam int unsigned TON_MANT_WIDTH     = 7;
   localparam int unsigned WORD_WIDTH         = 16;
   localparam logic [4:0]  EXP_FIXED          = 5'h00;

   // Reset values
   localparam logic [10:0] WARN_MANT_RESET    = 11'h078;
   localparam logic [6:0]  TON_MANT_RESET     = 7'h00;

   // Warning limit arithmetic, degrees Celsius
   localparam logic [11:0] WARN_HYSTERESIS    = 12'h014;
   localparam logic [10:0] DERIVE_OFFSET      = 11'h019;
   localparam logic [10:0] DERIVE_FLOOR       = 11'h064;
   localparam logic [10:0] WARN_MIN           = 11'h064;
   localparam logic [10:0] WARN_MAX           = 11'h08C;

   // Restart wait field codes and factor
   localparam logic [2:0]  RESTART_OFF        = 3'h0;
   localparam logic [2:0]  RESTART_CONT       = 3'h7;
   localparam int unsigned RESTART_BIT_POS    = 5;
   localparam logic [9:0]  RETRY_RISE_FACTOR  = 10'h007;

   // Vendor configuration bit position of the override
   localparam int unsigned OVERRIDE_BIT_POS   = 4;

   // Timing
   localparam int unsigned CLK_PERIOD_NS      = 25;
   localparam int unsigned MS_TIME_NS         = 1000000;
   localparam int unsigned SHORT_WAIT_NS      = 50000;
   localparam logic [15:0] MS_CYCLES          =
      16'((MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] SHORT_WAIT_CYCLES  =
      16'((SHORT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Restart controller states
   typedef enum logic [1:0]
   {
      RST_IDLE = 2'b00,
      RST_HOLD = 2'b01,
      RST_WAIT = 2'b10
   } otwtd_rst_state_t;

   // Programmed delay to one of sixteen supported delays, in ms
   function automatic logic [6:0] ton_bucket(input logic [6:0] mant);
      logic [6:0] ms;
      ms = 7'd100;
      if (mant <= 7'd6)
         ms = mant;
      else if (mant <= 7'd9)
         ms = 7'd7;
      else if (mant <= 7'd12)
         ms = 7'd10;
      else if (mant <= 7'd17)
         ms = 7'd14;
      else if (mant <= 7'd22)
         ms = 7'd19;
      else if (mant <= 7'd32)
         ms = 7'd27;
      else if (mant <= 7'd44)
         ms = 7'd37;
      else if (mant <= 7'd62)
         ms = 7'd52;
      else if (mant <= 7'd86)
         ms = 7'd72;
      return ms;
   endfunction : ton_bucket

endpackage : otwtd_pkg

// ---- src/otwtd_timer_if.sv ----
`timescale 1ns/1ps
interface otwtd_timer_if;
   logic       start;
   logic [9:0] wait_ms;
   logic       busy;
   logic       done;

   modport ctrl
   (
      output start,
      output wait_ms,
      input  busy,
      input  done
   );

   modport timer
   (
      input  start,
      input  wait_ms,
      output busy,
      output done
   );
endinterface : otwtd_timer_if

// ---- src/otwtd_delay_timer.sv ----
`timescale 1ns/1ps
module otwtd_delay_timer
#(
   parameter logic [15:0] P_MS_CYCLES    = otwtd_pkg::MS_CYCLES,
   parameter logic [15:0] P_SHORT_CYCLES = otwtd_pkg::SHORT_WAIT_CYCLES
)
(
   // Clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   // Timer handshake
   otwtd_timer_if.timer tmr
);
   import otwtd_pkg::*;

   logic [15:0] cycle_left;
   logic [9:0]  ms_left;
   logic        busy;
   logic        done;

   wire         ms_tick   = busy && (cycle_left == 16'h0000);
   wire         last_tick = ms_tick && (ms_left == 10'h000);
   wire         take      = tmr.start && !busy;

   // Millisecond divider and countdown; zero wait gives the short wait
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cycle_left <= 16'h0000;
         ms_left    <= 10'h000;
         busy       <= 1'b0;
         done       <= 1'b0;
      end
      else
      begin
         done <= last_tick;
         if (take)
         begin
            busy       <= 1'b1;
            cycle_left <= (tmr.wait_ms == 10'h000) ?
                          P_SHORT_CYCLES - 16'h0001 :
                          P_MS_CYCLES - 16'h0001;
            ms_left    <= (tmr.wait_ms == 10'h000) ?
                          10'h000 : tmr.wait_ms - 10'h001;
         end
         else if (last_tick)
            busy <= 1'b0;
         else if (ms_tick)
         begin
            ms_left    <= ms_left - 10'h001;
            cycle_left <= P_MS_CYCLES - 16'h0001;
         end
         else if (busy)
            cycle_left <= cycle_left - 16'h0001;
      end
   end

   assign tmr.busy = busy;
   assign tmr.done = done;

endmodule : otwtd_delay_timer

// ---- src/otwtd_top.sv ----
`timescale 1ns/1ps
// Contract
// - Retry wait 000 means no restart; output held off until faults clear.
// - Retry wait 111 waits seven rise times, then restarts with soft start.
// - All three retry wait bits mirror stored restart bit five.
// - Raise warning when sensed temperature exceeds the warning limit.
// - Warning sets temperature summary, warning status bit and alert.
// - Warning stays latched until temperature is 20 degrees below limit.
// - Limit at or above fault limit is dropped, flags invalid data, alerts.
// - Override bit four of vendor config skips the ordering check.
// - Load default warning is fault limit minus 25, floored at 100.
// - Warning exponent is read-only zero; one step is one degree.
// - Warning mantissa is low eleven bits, writable, default 120.
// - Warning mantissa must lie between 100 and 140 degrees; override also skips this check, load default is not capped at 140.
// - Turn-on delay separates start request from output ramp start.
// - Loop follower ignores and NACKs delay access, flags bad command.
// - Store-all copies turn-on delay into nonvolatile storage.
// - Delay word is linear, exponent zero, mantissa default zero.
// - Delay mantissa selects one of sixteen delays; zero gives 50 us.
module otwtd_top
#(
   parameter logic [15:0] P_MS_CYCLES = otwtd_pkg::MS_CYCLES
)
(
   // Clock and reset
   input  wire logic                              i_ref_clk,
   input  wire logic                              i_rst_n,
   // Decoded command port
   input  wire logic                              i_cmd_valid,
   input  wire logic                              i_cmd_write,
   input  wire logic [7:0]                        i_cmd_code,
   input  wire logic [otwtd_pkg::WORD_WIDTH-1:0]  i_cmd_wdata,
   output      logic                              o_rsp_valid,
   output      logic                              o_rsp_ack,
   output      logic [otwtd_pkg::WORD_WIDTH-1:0]  o_rsp_rdata,
   // Configuration from neighbouring logic
   input  wire logic [7:0]                        i_vendor_config_reg,
   input  wire logic [7:0]                        i_fault_response,
   input  wire logic [otwtd_pkg::MANT_WIDTH-1:0]  i_hot_fault_level,
   input  wire logic                              i_loop_follower_pin,
   // Load and nonvolatile storage
   input  wire logic                              i_load,
   input  wire logic [6:0]                        i_nv_power_on_wait_time,
   input  wire logic                              i_store_all,
   output      logic                              o_nv_store,
   output      logic [6:0]                        o_nv_power_on_wait_time,
   // Temperature samples and fault clear
   input  wire logic                              i_temp_valid,
   input  wire logic [otwtd_pkg::MANT_WIDTH-1:0]  i_temp,
   input  wire logic                              i_clear_faults,
   // Status
   output      logic                              o_status_temperature,
   output      logic                              o_hot_warning_level,
   output      logic                              o_status_cml,
   output      logic                              o_cml_invalid_data,
   output      logic                              o_bad_command_fault,
   output      logic                              o_smbalert,
   // Sequencing
   input  wire logic                              i_start_request,
   output      logic                              o_ramp_start,
   input  wire logic                              i_ot_shutdown,
   input  wire logic [6:0]                        i_rise_ms,
   output      logic [2:0]                        o_restart_wait_field,
   output      logic                              o_restart_hold,
   output      logic                              o_restart
);
   import otwtd_pkg::*;

   logic [MANT_WIDTH-1:0]     warn_mant;
   logic [TON_MANT_WIDTH-1:0] ton_mant;
   logic                      lf_s1;
   logic                      lf_s2;
   logic                      lf_s3;
   logic                      loop_follower;
   logic                      warn_flag;
   logic                      invalid_data;
   logic                      bad_command;
   logic                      cml_flag;
   otwtd_rst_state_t          rst_state;
   otwtd_rst_state_t          next_rst_state;

   otwtd_timer_if ton_tmr ();
   otwtd_timer_if rty_tmr ();

   // Strap synchroniser, change accepted when stages two and three agree
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         lf_s1         <= 1'b0;
         lf_s2         <= 1'b0;
         lf_s3         <= 1'b0;
         loop_follower <= 1'b0;
      end
      else
      begin
         lf_s1 <= i_loop_follower_pin;
         lf_s2 <= lf_s1;
         lf_s3 <= lf_s2;
         if (lf_s2 == lf_s3)
            loop_follower <= lf_s3;
      end
   end

   // Command decode
   wire [MANT_WIDTH-1:0] wr_mant     = i_cmd_wdata[MANT_WIDTH-1:0];
   wire                  hit_warn    = i_cmd_valid &&
                                       (i_cmd_code == CMD_WARN_LIMIT);
   wire                  hit_ton     = i_cmd_valid &&
                                       (i_cmd_code == CMD_POWER_ON_WAIT_TIME);
   wire                  override    = i_vendor_config_reg[OVERRIDE_BIT_POS];
   wire                  warn_write  = hit_warn && i_cmd_write;
   wire                  bad_order   = wr_mant >= i_hot_fault_level;
   wire                  bad_range   = (wr_mant < WARN_MIN) ||
                                       (wr_mant > WARN_MAX);
   wire                  warn_reject = warn_write && !override &&
                                       (bad_order || bad_range);
   wire                  warn_accept = warn_write && !warn_reject;
   wire                  ton_blocked = hit_ton && loop_follower;
   wire                  ton_write   = hit_ton && i_cmd_write &&
                                       !loop_follower;
   wire                  cmd_hit     = hit_warn || (hit_ton &&
                                       !loop_follower);

   // Read words with fixed zero exponents
   wire [WORD_WIDTH-1:0] warn_word   = {EXP_FIXED, warn_mant};
   wire [WORD_WIDTH-1:0] ton_word    = {EXP_FIXED, 4'h0, ton_mant};
   wire [WORD_WIDTH-1:0] read_word   = hit_warn ? warn_word :
                                       (hit_ton ? ton_word : 16'h0000);

   // Load-time default warning limit
   wire                  derive_low  = i_hot_fault_level <
                                       (DERIVE_FLOOR + DERIVE_OFFSET);
   wire [MANT_WIDTH-1:0] derived     = derive_low ? DERIVE_FLOOR :
                                       i_hot_fault_level - DERIVE_OFFSET;

   // Warning limit and turn-on delay storage
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         warn_mant <= WARN_MANT_RESET;
         ton_mant  <= TON_MANT_RESET;
      end
      else
      begin
         if (i_load)
         begin
            warn_mant <= derived;
            ton_mant  <= i_nv_power_on_wait_time;
         end
         else
         begin
            if (warn_accept)
               warn_mant <= wr_mant;
            if (ton_write)
               ton_mant <= i_cmd_wdata[TON_MANT_WIDTH-1:0];
         end
      end
   end

   // Command response, NACK for blocked or unknown codes
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_rsp_valid <= 1'b0;
         o_rsp_ack   <= 1'b0;
         o_rsp_rdata <= 16'h0000;
      end
      else
      begin
         o_rsp_valid <= i_cmd_valid;
         o_rsp_ack   <= cmd_hit;
         o_rsp_rdata <= (cmd_hit && !i_cmd_write) ? read_word : 16'h0000;
      end
   end

   // Nonvolatile copy of the turn-on delay
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_nv_store     <= 1'b0;
         o_nv_power_on_wait_time <= 7'h00;
      end
      else
      begin
         o_nv_store <= i_store_all;
         if (i_store_all)
            o_nv_power_on_wait_time <= ton_mant;
      end
   end

   // Warning compare and release with hysteresis
   wire temp_above    = i_temp > warn_mant;
   wire temp_released = ({1'b0, i_temp} + WARN_HYSTERESIS) <=
                        {1'b0, warn_mant};
   wire warn_set      = i_temp_valid && temp_above;
   wire warn_clr      = (i_temp_valid && temp_released) || i_clear_faults;
   wire next_warn     = warn_set || (warn_flag && !warn_clr);
   wire next_invalid  = warn_reject || (invalid_data && !i_clear_faults);
   wire next_bad_cmd  = ton_blocked || (bad_command && !i_clear_faults);
   wire next_cml      = warn_reject || ton_blocked ||
                        (cml_flag && !i_clear_faults);

   // Sticky status, set wins over clear
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         warn_flag    <= 1'b0;
         invalid_data <= 1'b0;
         bad_command  <= 1'b0;
         cml_flag     <= 1'b0;
         o_smbalert   <= 1'b0;
      end
      else
      begin
         warn_flag    <= next_warn;
         invalid_data <= next_invalid;
         bad_command  <= next_bad_cmd;
         cml_flag     <= next_cml;
         o_smbalert   <= next_warn || next_cml;
      end
   end

   assign o_status_temperature = warn_flag;
   assign o_hot_warning_level  = warn_flag;
   assign o_status_cml         = cml_flag;
   assign o_cml_invalid_data   = invalid_data;
   assign o_bad_command_fault  = bad_command;

   // Turn-on delay sequencing
   assign ton_tmr.start   = i_start_request && !ton_tmr.busy;
   assign ton_tmr.wait_ms = {3'b000, ton_bucket(ton_mant)};

   otwtd_delay_timer
   #(
      .P_MS_CYCLES    (P_MS_CYCLES),
      .P_SHORT_CYCLES (SHORT_WAIT_CYCLES)
   )
   u_ton_timer
   (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .tmr       (ton_tmr)
   );

   // Restart after over-temperature shutdown
   wire [2:0] wait_field = {3{i_fault_response[RESTART_BIT_POS]}};
   wire       go_hold    = i_ot_shutdown &&
                           (wait_field == RESTART_OFF);
   wire       go_wait    = i_ot_shutdown &&
                           (wait_field == RESTART_CONT);

   assign rty_tmr.start   = (rst_state == RST_IDLE) && go_wait;
   assign rty_tmr.wait_ms = {3'b000, i_rise_ms} * RETRY_RISE_FACTOR;

   otwtd_delay_timer
   #(
      .P_MS_CYCLES    (P_MS_CYCLES),
      .P_SHORT_CYCLES (SHORT_WAIT_CYCLES)
   )
   u_retry_timer
   (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .tmr       (rty_tmr)
   );

   always_comb
   begin
      next_rst_state = rst_state;
      case (rst_state)
         RST_IDLE:
            if (go_hold)
               next_rst_state = RST_HOLD;
            else if (go_wait)
               next_rst_state = RST_WAIT;
         RST_HOLD:
            if (i_clear_faults)
               next_rst_state = RST_IDLE;
         RST_WAIT:
            if (rty_tmr.done)
               next_rst_state = RST_IDLE;
         default:
            next_rst_state = RST_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rst_state    <= RST_IDLE;
         o_restart    <= 1'b0;
         o_ramp_start <= 1'b0;
      end
      else
      begin
         rst_state    <= next_rst_state;
         o_restart    <= (rst_state == RST_WAIT) && rty_tmr.done;
         o_ramp_start <= ton_tmr.done;
      end
   end

   assign o_restart_wait_field = wait_field;
   assign o_restart_hold       = (rst_state == RST_HOLD);

endmodule : otwtd_top

// ---- test/otwtd_host_model.sv ----
`timescale 1ns/1ps
module otwtd_host_model
(
   // Clock
   input  wire logic        i_ref_clk,
   // Command side
   output      logic        o_cmd_valid,
   output      logic        o_cmd_write,
   output      logic [7:0]  o_cmd_code,
   output      logic [15:0] o_cmd_wdata,
   // Response side
   input  wire logic        i_rsp_valid,
   input  wire logic        i_rsp_ack,
   input  wire logic [15:0] i_rsp_rdata
);
   initial
   begin
      o_cmd_valid = 1'b0;
      o_cmd_write = 1'b0;
      o_cmd_code  = 8'h00;
      o_cmd_wdata = 16'h0000;
   end

   // One command; idle lines never keep the last word
   task automatic xfer(input logic wr, input logic [7:0] code,
                       input logic [15:0] wd, output logic ack,
                       output logic [15:0] rd);
      @(posedge i_ref_clk);
      o_cmd_valid <= 1'b1;
      o_cmd_write <= wr;
      o_cmd_code  <= code;
      o_cmd_wdata <= wd;
      @(posedge i_ref_clk);
      o_cmd_valid <= 1'b0;
      o_cmd_write <= ~wr;
      o_cmd_code  <= ~code;
      o_cmd_wdata <= ~wd;
      #1;
      ack = i_rsp_valid ? i_rsp_ack : 1'bx;
      rd  = i_rsp_valid ? i_rsp_rdata : 16'hxxxx;
   endtask : xfer
endmodule : otwtd_host_model

// ---- test/otwtd_properties.sv ----
`timescale 1ns/1ps
module otwtd_properties
#(
   parameter logic [15:0] P_MS_CYCLES = otwtd_pkg::MS_CYCLES
)
(
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   // Inputs watched
   input  wire logic        i_cmd_valid,
   input  wire logic [7:0]  i_fault_response,
   input  wire logic        i_store_all,
   input  wire logic        i_temp_valid,
   input  wire logic        i_clear_faults,
   input  wire logic        i_ot_shutdown,
   // Outputs watched
   input  wire logic        o_rsp_valid,
   input  wire logic        o_rsp_ack,
   input  wire logic [15:0] o_rsp_rdata,
   input  wire logic        o_nv_store,
   input  wire logic        o_status_temperature,
   input  wire logic        o_hot_warning_level,
   input  wire logic        o_status_cml,
   input  wire logic        o_cml_invalid_data,
   input  wire logic        o_bad_command_fault,
   input  wire logic        o_smbalert,
   input  wire logic [2:0]  o_restart_wait_field,
   input  wire logic        o_restart_hold,
   input  wire logic        o_restart
);
   import otwtd_pkg::*;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   rsp_pulse_a: assert property (i_cmd_valid |=> o_rsp_valid)
      else $error("response missing");
   exp_zero_a: assert property (
      o_rsp_valid |-> o_rsp_rdata[15:11] == 5'h00)
      else $error("exponent not zero");
   wait_mirror_a: assert property (
      o_restart_wait_field == {3{i_fault_response[5]}})
      else $error("wait field not mirrored");
   warn_cause_a: assert property (
      $rose(o_hot_warning_level) |-> $past(i_temp_valid))
      else $error("warning without sample");
   warn_release_a: assert property (
      $fell(o_hot_warning_level) |->
         $past(i_temp_valid) || $past(i_clear_faults))
      else $error("warning released without cause");
   warn_flags_a: assert property (
      o_status_temperature |-> o_hot_warning_level && o_smbalert)
      else $error("warning flags disagree");
   alert_cause_a: assert property (
      o_smbalert == (o_status_temperature || o_status_cml))
      else $error("alert mismatch");
   ivd_flags_a: assert property (
      $rose(o_cml_invalid_data) |-> o_status_cml && $past(i_cmd_valid))
      else $error("invalid data flag wrong");
   bad_nack_a: assert property (
      $rose(o_bad_command_fault) |->
         o_rsp_valid && !o_rsp_ack && o_status_cml)
      else $error("bad command without nack");
   store_pulse_a: assert property (i_store_all |=> o_nv_store)
      else $error("store missing");
   hold_cause_a: assert property (
      $rose(o_restart_hold) |->
         $past(i_ot_shutdown) && o_restart_wait_field == 3'h0)
      else $error("hold without shutdown");
   restart_mode_a: assert property (
      o_restart |-> o_restart_wait_field == 3'h7 && !o_restart_hold)
      else $error("restart in wrong mode");
endmodule : otwtd_properties

bind otwtd_top otwtd_properties #(.P_MS_CYCLES(P_MS_CYCLES)) i_chk
(
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
   .i_fault_response(i_fault_response), .i_store_all(i_store_all),
   .i_temp_valid(i_temp_valid), .i_clear_faults(i_clear_faults),
   .i_ot_shutdown(i_ot_shutdown), .o_rsp_valid(o_rsp_valid),
   .o_rsp_ack(o_rsp_ack), .o_rsp_rdata(o_rsp_rdata),
   .o_nv_store(o_nv_store), .o_status_temperature(o_status_temperature),
   .o_hot_warning_level(o_hot_warning_level),
   .o_status_cml(o_status_cml), .o_cml_invalid_data(o_cml_invalid_data),
   .o_bad_command_fault(o_bad_command_fault), .o_smbalert(o_smbalert),
   .o_restart_wait_field(o_restart_wait_field),
   .o_restart_hold(o_restart_hold), .o_restart(o_restart)
);

// ---- test/otwtd_tb_top.sv ----
`timescale 1ns/1ps
module otwtd_tb_top;
   import otwtd_pkg::*;
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin \
   num_errors++; $display("mismatch %0t %s", $time, m); end end

   logic        clk = 1'b0, rst_n = 1'b0, lf = 1'b0, tv = 1'b0;
   logic        ack;
   logic [4:0]  pls = 5'h00;
   localparam int load = 0, store = 1, clr = 2, start = 3, shut = 4;
   logic [7:0]  vcfg = 8'h00, fresp = 8'h00;
   logic [10:0] flt = 11'h091, temp = 11'h000;
   logic [6:0]  nvd = 7'h00, rise = 7'h01;
   logic [15:0] rdat;
   wire         cv, cw, rv, ra, nvs, st, hw, sc, ivd, bcf, al, ramp;
   wire         hold, rs;
   wire [7:0]   cc;
   wire [15:0]  cd, rd;
   wire [6:0]   nvo;
   wire [2:0]   wf;
   int          num_errors = 0, check_count = 0, n;
   logic [6:0]  mt [5] = '{7'h00, 7'h03, 7'h0A, 7'h56, 7'h57};
   int          wt [5] = '{2001, 61, 201, 1441, 2001};

   always #12.5 clk = ~clk;

   otwtd_host_model i_host
   (
      .i_ref_clk(clk), .o_cmd_valid(cv), .o_cmd_write(cw),
      .o_cmd_code(cc), .o_cmd_wdata(cd), .i_rsp_valid(rv),
      .i_rsp_ack(ra), .i_rsp_rdata(rd)
   );

   otwtd_top #(.P_MS_CYCLES(16'h0014)) i_dut
   (
      .i_ref_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(cv),
      .i_cmd_write(cw), .i_cmd_code(cc), .i_cmd_wdata(cd),
      .o_rsp_valid(rv), .o_rsp_ack(ra), .o_rsp_rdata(rd),
      .i_vendor_config_reg(vcfg), .i_fault_response(fresp),
      .i_hot_fault_level(flt), .i_loop_follower_pin(lf),
      .i_load(pls[load]), .i_nv_power_on_wait_time(nvd),
      .i_store_all(pls[store]), .o_nv_store(nvs),
      .o_nv_power_on_wait_time(nvo), .i_temp_valid(tv), .i_temp(temp),
      .i_clear_faults(pls[clr]), .o_status_temperature(st),
      .o_hot_warning_level(hw), .o_status_cml(sc),
      .o_cml_invalid_data(ivd), .o_bad_command_fault(bcf),
      .o_smbalert(al), .i_start_request(pls[start]),
      .o_ramp_start(ramp), .i_ot_shutdown(pls[shut]), .i_rise_ms(rise),
      .o_restart_wait_field(wf), .o_restart_hold(hold), .o_restart(rs)
   );

   task automatic cmd(input logic w, input logic [7:0] c,
                      input logic [15:0] d, input logic ea,
                      input logic [15:0] er);
      i_host.xfer(w, c, d, ack, rdat);
      `CHK(ack, ea, "ack")
      `CHK(rdat, er, "data")
   endtask : cmd

   task automatic pulse(input int b);
      @(posedge clk);
      pls[b] <= 1'b1;
      @(posedge clk);
      pls[b] <= 1'b0;
      #1;
   endtask : pulse

   task automatic sample(input logic [10:0] t, input logic e);
      @(posedge clk);
      temp <= t;
      tv   <= 1'b1;
      @(posedge clk);
      tv   <= 1'b0;
      temp <= ~t;
      #1;
      `CHK(hw, e, "warning level")
      `CHK(al, e, "alert")
   endtask : sample

   task automatic t_reset();
      cmd(0, 8'h51, 16'h0000, 1'b1, 16'h0078);
      cmd(0, 8'h60, 16'h0000, 1'b1, 16'h0000);
      cmd(0, 8'h52, 16'h0000, 1'b0, 16'h0000);
   endtask : t_reset

   task automatic t_limit();
      cmd(1, 8'h51, 16'hF88C, 1'b1, 16'h0000);
      cmd(0, 8'h51, 16'h0000, 1'b1, 16'h008C);
      cmd(1, 8'h51, 16'h008D, 1'b1, 16'h0000);
      `CHK(ivd, 1'b1, "range reject")
      pulse(clr);
      @(posedge clk);
      flt <= 11'h082;
      cmd(1, 8'h51, 16'h0083, 1'b1, 16'h0000);
      `CHK({ivd, sc, al}, 3'h7, "order reject flags")
      cmd(0, 8'h51, 16'h0000, 1'b1, 16'h008C);
      pulse(clr);
      @(posedge clk);
      vcfg <= 8'h10;
      cmd(1, 8'h51, 16'h0083, 1'b1, 16'h0000);
      `CHK(ivd, 1'b0, "override")
      cmd(0, 8'h51, 16'h0000, 1'b1, 16'h0083);
      @(posedge clk);
      vcfg <= 8'h00;
      flt  <= 11'h091;
   endtask : t_limit

   task automatic t_warn();
      sample(11'h083, 1'b0);
      sample(11'h084, 1'b1);
      `CHK(st, 1'b1, "summary bit")
      sample(11'h070, 1'b1);
      sample(11'h06F, 1'b0);
   endtask : t_warn

   task automatic t_load();
      @(posedge clk);
      flt <= 11'h06E;
      pulse(load);
      cmd(0, 8'h51, 16'h0000, 1'b1, 16'h0064);
      @(posedge clk);
      flt <= 11'h091;
      nvd <= 7'h09;
      pulse(load);
      cmd(0, 8'h51, 16'h0000, 1'b1, 16'h0078);
      cmd(0, 8'h60, 16'h0000, 1'b1, 16'h0009);
   endtask : t_load

   task automatic t_delay();
      for (int i = 0; i < 5; i++)
      begin
         cmd(1, 8'h60, {9'h1F0, mt[i]}, 1'b1, 16'h0000);
         pulse(start);
         n = 0;
         while (ramp !== 1'b1 && n < 2100)
         begin
            @(posedge clk);
            #1;
            n++;
         end
         `CHK(n, wt[i], "turn-on wait")
         pulse(store);
         `CHK({nvs, nvo}, {1'b1, mt[i]}, "store")
      end
   endtask : t_delay

   task automatic t_follow();
      @(posedge clk);
      lf <= 1'b1;
      repeat (6) @(posedge clk);
      cmd(1, 8'h60, 16'h0005, 1'b0, 16'h0000);
      `CHK({bcf, al}, 2'h3, "bad command")
      cmd(0, 8'h60, 16'h0000, 1'b0, 16'h0000);
      lf <= 1'b0;
      repeat (6) @(posedge clk);
      pulse(clr);
      cmd(0, 8'h60, 16'h0000, 1'b1, 16'h0057);
   endtask : t_follow

   task automatic t_restart();
      `CHK(wf, 3'h0, "wait field off")
      pulse(shut);
      repeat (10) @(posedge clk);
      #1;
      `CHK({hold, rs}, 2'h2, "hold off")
      pulse(clr);
      @(posedge clk);
      #1;
      `CHK(hold, 1'b0, "hold cleared")
      fresp <= 8'h20;
      @(posedge clk);
      #1;
      `CHK(wf, 3'h7, "wait field on")
      pulse(shut);
      n = 0;
      while (rs !== 1'b1 && n < 300)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK(n, 141, "restart wait")
   endtask : t_restart

   task automatic results();
      if (num_errors == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results

   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_limit();
      t_warn();
      t_load();
      t_delay();
      t_follow();
      t_restart();
      results();
   end

   initial
   begin
      #750000;
      num_errors++;
      results();
   end
endmodule : otwtd_tb_top
